// File: pkg/rxfb_consts.svh
`ifndef RXFB_CONSTS_SVH
`define RXFB_CONSTS_SVH

// ---------------------------------------------------------------
// Frame bytes
// ---------------------------------------------------------------
`define RXFB_DELIM          8'h7e
`define RXFB_TYPE_STD       8'h90
`define RXFB_TYPE_EXP       8'h91
`define RXFB_CSUM_BASE      8'hff
`define RXFB_SUM_FIRST      5'd3
`define RXFB_STD_LAST       5'd14
`define RXFB_EXP_LAST       5'd20
`define RXFB_STD_LEN        16'h000c
`define RXFB_EXP_LEN        16'h0012

// ---------------------------------------------------------------
// Receive options byte
// ---------------------------------------------------------------
`define RXFB_OPT_ACK        8'h01
`define RXFB_OPT_BCAST      8'h02
`define RXFB_OPT_ALLPAN     8'h04
`define RXFB_OPT_SECURE     8'h10
`define RXFB_OPT_APSENC     8'h20
`define RXFB_OPT_DLV_POS    6
`define RXFB_EP_LO          8'hdc
`define RXFB_EP_HI          8'hee

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define RXFB_ADR_CTRL       8'h00
`define RXFB_ADR_STATUS     8'h04
`define RXFB_ADR_FRAMES     8'h08
`define RXFB_CTRL_RST       32'h0000_0100
`define RXFB_CTRL_EN_BIT    8
`define RXFB_FMT_EXP_BIT    1

`endif

// File: pkg/rxfb_pkg.sv
package rxfb_pkg;

    typedef enum logic [1:0] {
        RXFB_IDLE = 2'b00,
        RXFB_HDR  = 2'b01,
        RXFB_PAY  = 2'b10,
        RXFB_CSUM = 2'b11
    } rxfb_state_e;

    // Delivery method, options bits 7:6
    typedef enum logic [1:0] {
        RXFB_DLV_INVALID = 2'b00,
        RXFB_DLV_P2MP    = 2'b01,
        RXFB_DLV_DIRBC   = 2'b10,
        RXFB_DLV_MESH    = 2'b11
    } rxfb_dlv_e;

    typedef struct packed {
        logic       ack;
        logic       bcast;
        logic       all_pan;
        logic       secure;
        logic       aps_enc;
        rxfb_dlv_e  delivery;
    } rxfb_flags_s;

    typedef struct packed {
        logic [63:0] src64;
        logic [15:0] src16;
        logic [7:0]  src_ep;
        logic [7:0]  dst_ep;
        logic [15:0] cluster;
        logic [15:0] profile;
        rxfb_flags_s flags;
        logic        mem_resp;
        logic [15:0] pay_len;
    } rxfb_hdr_s;

endpackage

// File: rtl/rxfb_csum.sv
`timescale 1ns/1ps
`default_nettype none
`include "rxfb_consts.svh"

module rxfb_csum
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       add_en,
    input  wire logic [7:0] din,
    output logic      [7:0] csum
);

    logic [7:0] sum_q;

    // ---------------------------------------------------------------
    // Running sum, carries out of bit 7 are dropped on purpose
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            sum_q <= 8'h00;
        else if (clr)
            sum_q <= 8'h00;
        else if (add_en)
            sum_q <= sum_q + din;
    end

    assign csum = `RXFB_CSUM_BASE - sum_q;

endmodule
`default_nettype wire

// File: rtl/rxfb_frame_builder.sv
// How it works
// - Every frame opens with 7e, then two length bytes, then the type byte.
// - The 16-bit length counts the bytes after the length field up to but not the checksum.
// - The checksum is ff minus the low byte of the sum of bytes from the type byte on.
// - With format option zero a received payload yields a standard frame of type 90.
// - The standard frame carries the 64-bit sender address at byte 4 and the 16-bit one at byte 12.
// - The standard frame has the options byte at 14 and payload from 15 to the checksum.
// - Options bit values 01 mark acknowledged, 02 broadcast and 10 secure session.
// - Options 04 marks broadcast across all networks, 20 application encryption, bit 3 reads zero.
// - Options bits 7:6 carry the delivery method: invalid, 40, 80 or c0.
// - Option flags are independent and several may be set in one byte.
// - With bit 1 of the format option set a payload yields an explicit frame of type 91.
// - The explicit frame has source endpoint at byte 14 and destination endpoint at 15.
// - The explicit frame has cluster at byte 16 and profile at byte 18.
// - The explicit options byte is at 20, payload from 21, flags only for endpoints dc to ee.
// - Responses of the onboard user memory always use the explicit frame.
`timescale 1ns/1ps
`default_nettype none
`include "rxfb_consts.svh"

module rxfb_frame_builder
#(
    parameter int PAY_LEN_W = 15
)
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Received packet header
    input  wire rxfb_pkg::rxfb_hdr_s hdr_i,
    input  wire logic              hdr_valid,
    output logic                   hdr_ready,
    // Payload bytes
    input  wire logic [7:0]        pay_data,
    input  wire logic              pay_valid,
    output logic                   pay_ready,
    // Serial API byte stream
    output logic      [7:0]        out_data,
    output logic                   out_valid,
    input  wire logic              out_ready
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    // Header bytes plus payload must fit the 16-bit length field
    if (PAY_LEN_W < 1 || PAY_LEN_W > 15)
    begin : g_bad_width
        $error("PAY_LEN_W must lie between 1 and 15");
    end

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    rxfb_pkg::rxfb_state_e state_q;
    rxfb_pkg::rxfb_hdr_s   hdr_q;
    logic                  exp_q;
    logic [15:0]           len_q;
    logic [4:0]            idx_q;
    logic [15:0]           pay_cnt_q;
    logic [31:0]           ctrl_q;
    logic [15:0]           frames_q;
    logic [31:0]           wb_dat_q;
    logic                  wb_ack_q;
    logic                  hdr_ready_q;
    logic                  pay_ready_q;
    logic [7:0]            out_data_q;
    logic                  out_valid_q;
    logic                  hdr_take;
    logic                  pay_take;
    logic                  slot_free;
    logic                  hdr_load;
    logic                  csum_load;
    logic                  use_exp;
    logic [4:0]            last_idx;
    logic [7:0]            opt_byte;
    logic [7:0]            cur_byte;
    logic [7:0]            csum;
    logic                  wb_req;
    logic                  fmt_en;
    logic [7:0]            fmt_opt;

    assign fmt_opt = ctrl_q[7:0];
    assign fmt_en  = ctrl_q[`RXFB_CTRL_EN_BIT];

    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wb_ack_q <= 1'b0;
        else
            wb_ack_q <= wb_req;
    end

    // Byte lanes 0 and 1 hold the format option and the enable; a write lands with its ack
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ctrl_q <= `RXFB_CTRL_RST;
        else if (wb_cyc_i && wb_stb_i && wb_ack_q && wb_we_i && wb_adr_i == `RXFB_ADR_CTRL)
        begin
            if (wb_sel_i[0])
                ctrl_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                ctrl_q[`RXFB_CTRL_EN_BIT] <= wb_dat_i[`RXFB_CTRL_EN_BIT];
        end
    end

    // Unmapped addresses read zero and ignore writes
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wb_dat_q <= 32'h0000_0000;
        else if (wb_req)
        begin
            case (wb_adr_i)
                `RXFB_ADR_CTRL:   wb_dat_q <= ctrl_q;
                `RXFB_ADR_STATUS: wb_dat_q <= {28'h0000000, exp_q, state_q, out_valid_q};
                `RXFB_ADR_FRAMES: wb_dat_q <= {16'h0000, frames_q};
                default:          wb_dat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;

    // ---------------------------------------------------------------
    // Frame selection
    // ---------------------------------------------------------------
    // Memory responses override the option; nonzero options without
    // bit 1 fall back to the standard form
    assign use_exp = hdr_i.mem_resp || fmt_opt[`RXFB_FMT_EXP_BIT];

    assign hdr_take = hdr_valid && hdr_ready_q;
    assign pay_take = pay_valid && pay_ready_q;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            hdr_q <= '0;
            exp_q <= 1'b0;
            len_q <= 16'h0000;
        end
        else if (hdr_take)
        begin
            hdr_q <= hdr_i;
            exp_q <= use_exp;
            // Length excludes delimiter, length bytes and checksum
            if (use_exp)
                len_q <= `RXFB_EXP_LEN + hdr_i.pay_len;
            else
                len_q <= `RXFB_STD_LEN + hdr_i.pay_len;
        end
    end

    // ---------------------------------------------------------------
    // Options byte
    // ---------------------------------------------------------------
    always_comb
    begin
        opt_byte = 8'h00;
        // Each flag is its own bit, so any mix may be set together
        if (hdr_q.flags.ack)
            opt_byte = opt_byte | `RXFB_OPT_ACK;
        if (hdr_q.flags.bcast)
            opt_byte = opt_byte | `RXFB_OPT_BCAST;
        if (hdr_q.flags.secure)
            opt_byte = opt_byte | `RXFB_OPT_SECURE;
        if (hdr_q.flags.all_pan)
            opt_byte = opt_byte | `RXFB_OPT_ALLPAN;
        if (hdr_q.flags.aps_enc)
            opt_byte = opt_byte | `RXFB_OPT_APSENC;
        opt_byte[`RXFB_OPT_DLV_POS +: 2] = hdr_q.flags.delivery;
        // In explicit frames flags only mean something on the reserved endpoint range
        if (exp_q && (hdr_q.dst_ep < `RXFB_EP_LO || hdr_q.dst_ep > `RXFB_EP_HI))
            opt_byte = 8'h00;
    end

    // ---------------------------------------------------------------
    // Header byte at the current index
    // ---------------------------------------------------------------
    always_comb
    begin
        cur_byte = 8'h00;
        case (idx_q)
            5'd0:  cur_byte = `RXFB_DELIM;
            5'd1:  cur_byte = len_q[15:8];
            5'd2:  cur_byte = len_q[7:0];
            5'd3:  cur_byte = exp_q ? `RXFB_TYPE_EXP : `RXFB_TYPE_STD;
            5'd4:  cur_byte = hdr_q.src64[63:56];
            5'd5:  cur_byte = hdr_q.src64[55:48];
            5'd6:  cur_byte = hdr_q.src64[47:40];
            5'd7:  cur_byte = hdr_q.src64[39:32];
            5'd8:  cur_byte = hdr_q.src64[31:24];
            5'd9:  cur_byte = hdr_q.src64[23:16];
            5'd10: cur_byte = hdr_q.src64[15:8];
            5'd11: cur_byte = hdr_q.src64[7:0];
            5'd12: cur_byte = hdr_q.src16[15:8];
            5'd13: cur_byte = hdr_q.src16[7:0];
            5'd14: cur_byte = exp_q ? hdr_q.src_ep : opt_byte;
            5'd15: cur_byte = hdr_q.dst_ep;
            5'd16: cur_byte = hdr_q.cluster[15:8];
            5'd17: cur_byte = hdr_q.cluster[7:0];
            5'd18: cur_byte = hdr_q.profile[15:8];
            5'd19: cur_byte = hdr_q.profile[7:0];
            5'd20: cur_byte = opt_byte;
            default: cur_byte = 8'h00;
        endcase
    end

    assign last_idx = exp_q ? `RXFB_EXP_LAST : `RXFB_STD_LAST;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // One byte at a time: a new byte loads only once the previous one
    // has left, which halves header throughput (payload moves one byte in three cycles) but needs no skid buffer
    assign slot_free = !out_valid_q && !pay_ready_q;
    assign hdr_load  = state_q == rxfb_pkg::RXFB_HDR && slot_free;
    assign csum_load = state_q == rxfb_pkg::RXFB_CSUM && slot_free;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q   <= rxfb_pkg::RXFB_IDLE;
            idx_q     <= 5'd0;
            pay_cnt_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                rxfb_pkg::RXFB_IDLE:
                begin
                    if (hdr_take)
                    begin
                        state_q   <= rxfb_pkg::RXFB_HDR;
                        idx_q     <= 5'd0;
                        pay_cnt_q <= hdr_i.pay_len;
                    end
                end
                rxfb_pkg::RXFB_HDR:
                begin
                    if (hdr_load)
                    begin
                        idx_q <= idx_q + 5'd1;
                        if (idx_q == last_idx)
                        begin
                            if (pay_cnt_q == 16'h0000)
                                state_q <= rxfb_pkg::RXFB_CSUM;
                            else
                                state_q <= rxfb_pkg::RXFB_PAY;
                        end
                    end
                end
                rxfb_pkg::RXFB_PAY:
                begin
                    if (pay_take)
                    begin
                        pay_cnt_q <= pay_cnt_q - 16'h0001;
                        if (pay_cnt_q == 16'h0001)
                            state_q <= rxfb_pkg::RXFB_CSUM;
                    end
                end
                rxfb_pkg::RXFB_CSUM:
                begin
                    if (csum_load)
                        state_q <= rxfb_pkg::RXFB_IDLE;
                end
                default:
                    state_q <= rxfb_pkg::RXFB_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Handshakes toward header and payload sources
    // ---------------------------------------------------------------
    // A new header waits until the previous checksum has left
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            hdr_ready_q <= 1'b0;
        else
            hdr_ready_q <= state_q == rxfb_pkg::RXFB_IDLE && fmt_en && !out_valid_q && !hdr_take;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pay_ready_q <= 1'b0;
        else if (pay_take)
            pay_ready_q <= 1'b0;
        else
            pay_ready_q <= state_q == rxfb_pkg::RXFB_PAY && !out_valid_q;
    end

    // ---------------------------------------------------------------
    // Output byte register
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            out_valid_q <= 1'b0;
            out_data_q  <= 8'h00;
        end
        else if (hdr_load)
        begin
            out_valid_q <= 1'b1;
            out_data_q  <= cur_byte;
        end
        else if (pay_take)
        begin
            out_valid_q <= 1'b1;
            out_data_q  <= pay_data;
        end
        else if (csum_load)
        begin
            out_valid_q <= 1'b1;
            out_data_q  <= csum;
        end
        else if (out_ready)
            out_valid_q <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            frames_q <= 16'h0000;
        else if (csum_load)
            frames_q <= frames_q + 16'h0001;
    end

    // ---------------------------------------------------------------
    // Checksum
    // ---------------------------------------------------------------
    rxfb_csum u_csum
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clr     (hdr_take),
        .add_en  ((hdr_load && idx_q >= `RXFB_SUM_FIRST) || pay_take),
        .din     (pay_take ? pay_data : cur_byte),
        .csum    (csum)
    );

    assign hdr_ready = hdr_ready_q;
    assign pay_ready = pay_ready_q;
    assign out_data  = out_data_q;
    assign out_valid = out_valid_q;

endmodule
`default_nettype wire

// File: verification/rxfb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Stream checker
// ------------------------------------------------
module rxfb_monitor
(
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 wb_cyc_i,
    input wire logic                 wb_stb_i,
    input wire logic                 wb_we_i,
    input wire logic [7:0]           wb_adr_i,
    input wire logic [3:0]           wb_sel_i,
    input wire logic [31:0]          wb_dat_i,
    input wire logic [31:0]          wb_dat_o,
    input wire logic                 wb_ack_o,
    input wire rxfb_pkg::rxfb_hdr_s  hdr_i,
    input wire logic                 hdr_valid,
    input wire logic                 hdr_ready,
    input wire logic [7:0]           pay_data,
    input wire logic                 pay_valid,
    input wire logic                 pay_ready,
    input wire logic [7:0]           out_data,
    input wire logic                 out_valid,
    input wire logic                 out_ready
);
    logic [7:0] idx_q;
    logic [7:0] len_q;
    logic [7:0] sum_q;
    logic       take;
    logic       acc;
    assign take = hdr_valid && hdr_ready;
    assign acc  = out_valid && out_ready;
    // Length reset high so the checksum slot never matches before a frame
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            idx_q <= 8'h00;
            len_q <= 8'hf0;
            sum_q <= 8'h00;
        end
        else if (take)
        begin
            idx_q <= 8'h00;
            sum_q <= 8'h00;
        end
        else if (acc)
        begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == 8'h02)
                len_q <= out_data;
            if (idx_q >= 8'h03)
                sum_q <= sum_q + out_data;
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stream byte changed before acceptance");
    AST_SOF: assert property (take |-> ##2 out_valid && out_data == 8'h7e)
        else $error("delimiter missing after header");
    AST_HDR_BLOCK: assert property (out_valid |-> !hdr_ready)
        else $error("header offered during a frame");
    AST_HDR_DROP: assert property (take |=> !hdr_ready [*2])
        else $error("header ready stayed high");
    AST_TYPE: assert property (out_valid && idx_q == 8'h03 |-> out_data inside {8'h90, 8'h91})
        else $error("bad frame type byte");
    AST_PAY_ECHO: assert property (pay_valid && pay_ready |=> out_valid && out_data == $past(pay_data))
        else $error("payload byte not forwarded");
    AST_CSUM: assert property (out_valid && idx_q == len_q + 8'h03 |-> out_data == 8'hff - sum_q)
        else $error("bad checksum byte");
endmodule
bind rxfb_frame_builder rxfb_monitor u_mon
(
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hdr_i(hdr_i), .hdr_valid(hdr_valid),
    .hdr_ready(hdr_ready), .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready)
);
`default_nettype wire

// File: verification/rxfb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// Host byte sink
// ------------------------------------------------
module rxfb_host_model
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic [7:0] out_data,
    input  wire logic       out_valid,
    output logic            out_ready
);
    logic [7:0] rx_q[$];
    logic [1:0] cnt_q;
    // Slow mode takes one byte in four, so the stream must hold each byte
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q     <= 2'h0;
            out_ready <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_q + 2'h1;
            out_ready <= slow ? (cnt_q == 2'h3) : 1'b1;
        end
    end
    // Bytes kept whole for parsing; the testbench compares them byte by byte
    always @(posedge ref_clk)
        if (!rst && out_valid && out_ready)
            rx_q.push_back(out_data);
endmodule
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                ref_clk   = 1'b0;
    logic                rst       = 1'b1;
    logic                wb_cyc_i  = 1'b0;
    logic                wb_stb_i  = 1'b0;
    logic                wb_we_i   = 1'b0;
    logic [7:0]          wb_adr_i  = 8'h00;
    logic [3:0]          wb_sel_i  = 4'h0;
    logic [31:0]         wb_dat_i  = 32'h0;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    rxfb_pkg::rxfb_hdr_s hdr_i     = '0;
    rxfb_pkg::rxfb_hdr_s h         = '0;
    logic                hdr_valid = 1'b0;
    logic                hdr_ready;
    logic [7:0]          pay_data  = 8'h00;
    logic                pay_valid = 1'b0;
    logic                pay_ready;
    logic [7:0]          out_data;
    logic                out_valid;
    logic                out_ready;
    logic                slow      = 1'b0;
    int                  failures  = 0;
    int                  checks    = 0;
    rxfb_frame_builder DUT (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .hdr_i, .hdr_valid, .hdr_ready, .pay_data, .pay_valid,
        .pay_ready, .out_data, .out_valid, .out_ready);
    rxfb_host_model host (.ref_clk, .rst, .slow, .out_data, .out_valid, .out_ready);
    always #5 ref_clk = ~ref_clk;
    // ------------------------------------------------
    // Shared tasks
    // ------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        chk("bus ack", 32'h1, {31'h0, wb_ack_o});
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hf, q);
        chk("register read", e, q);
    endtask
    // Expected frame is built from the field layout, then driven and compared
    task automatic run_frame(input logic x);
        logic [7:0] e[$];
        logic [7:0] o;
        logic [7:0] s;
        int         base;
        int         n;
        e = {8'h7e, 8'h00, 8'h00, x ? 8'h91 : 8'h90};
        for (int i = 7; i >= 0; i--)
            e.push_back(h.src64[i*8+:8]);
        e = {e, h.src16[15:8], h.src16[7:0]};
        if (x)
            e = {e, h.src_ep, h.dst_ep, h.cluster[15:8], h.cluster[7:0], h.profile[15:8], h.profile[7:0]};
        o = {h.flags.delivery, h.flags.aps_enc, h.flags.secure, 1'b0, h.flags.all_pan, h.flags.bcast,
            h.flags.ack};
        if (x && (h.dst_ep < 8'hdc || h.dst_ep > 8'hee))
            o = 8'h00;
        e.push_back(o);
        for (int i = 0; i < h.pay_len; i++)
            e.push_back(8'ha0 + 8'(i));
        e[1] = 8'((e.size() - 3) >> 8);
        e[2] = 8'(e.size() - 3);
        s = 8'h00;
        for (int i = 3; i < e.size(); i++)
            s = s + e[i];
        e.push_back(8'hff - s);
        base = host.rx_q.size();
        n = 0;
        @(posedge ref_clk);
        hdr_i     <= h;
        hdr_valid <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hdr_ready !== 1'b1 && n < 100);
        hdr_valid <= 1'b0;
        for (int i = 0; i < h.pay_len; i++)
        begin
            pay_data  <= 8'ha0 + 8'(i);
            pay_valid <= 1'b1;
            do
            begin
                @(posedge ref_clk);
                n++;
            end
            while (pay_ready !== 1'b1 && n < 2000);
        end
        pay_valid <= 1'b0;
        while (host.rx_q.size() < base + e.size() && n < 3000)
        begin
            @(posedge ref_clk);
            n++;
        end
        for (int i = 0; i < e.size(); i++)
            chk("frame byte", e[i], host.rx_q[base+i]);
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_regs();
        logic [31:0] q;
        rchk(8'h00, 32'h100);
        rchk(8'h04, 32'h0);
        rchk(8'h08, 32'h0);
        wb(1'b1, 8'h0c, 32'hffffffff, 4'hf, q);
        rchk(8'h0c, 32'h0);
    endtask
    task automatic t_std();
        h.flags   = 7'b1001011;
        h.pay_len = 16'h3;
        run_frame(1'b0);
        rchk(8'h08, 32'h1);
    endtask
    task automatic t_exp_slow();
        logic [31:0] q;
        wb(1'b1, 8'h00, 32'h102, 4'h3, q);
        h.dst_ep  = 8'hdc;
        h.flags   = 7'b0110101;
        h.pay_len = 16'h4;
        slow      <= 1'b1;
        run_frame(1'b1);
        slow      <= 1'b0;
    endtask
    task automatic t_exp_ep_out();
        h.dst_ep  = 8'hef;
        h.flags   = 7'b1111111;
        h.pay_len = 16'h1;
        run_frame(1'b1);
    endtask
    task automatic t_mem();
        logic [31:0] q;
        wb(1'b1, 8'h00, 32'h101, 4'h3, q);
        h.mem_resp = 1'b1;
        h.dst_ep   = 8'hee;
        h.flags    = 7'b0100010;
        h.pay_len  = 16'h2;
        run_frame(1'b1);
        h.mem_resp = 1'b0;
        h.flags    = 7'b0001000;
        run_frame(1'b0);
    endtask
    // Enable cleared through its own byte lane keeps the format byte
    task automatic t_disable();
        logic [31:0] q;
        wb(1'b1, 8'h00, 32'hff, 4'h2, q);
        rchk(8'h00, 32'h001);
        hdr_i     <= h;
        hdr_valid <= 1'b1;
        repeat (20)
        begin
            @(posedge ref_clk);
            chk("header ready", 32'h0, {31'h0, hdr_ready});
        end
        hdr_valid <= 1'b0;
        wb(1'b1, 8'h00, 32'h100, 4'h2, q);
        rchk(8'h00, 32'h101);
        rchk(8'h08, 32'h5);
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
    end
    initial
    begin
        #300us;
        failures++;
        print_verdict();
    end
    initial
    begin
        h.src64   = 64'h0123456789abcdef;
        h.src16   = 16'h5614;
        h.src_ep  = 8'he8;
        h.dst_ep  = 8'he8;
        h.cluster = 16'h0011;
        h.profile = 16'hc105;
        wait (rst == 1'b0);
        t_regs();
        t_std();
        t_exp_slow();
        t_exp_ep_out();
        t_mem();
        t_disable();
        print_verdict();
    end
endmodule
`default_nettype wire
